// file: dbsp_ctrl.sv
// controller model: input clock pair, commands and write beats
`timescale 1ns/1ps
`default_nettype none
module dbsp_ctrl #(
  parameter int AW = 4
) (
  input  wire logic          clk,
  input  wire logic          go,
  input  wire logic          dll_off_n,
  output logic               in_clk,
  output logic               in_clk_n,
  output logic               read_sel_n,
  output logic               write_sel_n,
  output logic [AW-1:0]      addr_in,
  output logic [35:0]        write_data_in,
  output logic [3:0]         byte_lane_write_n
);
  // ******************************
  // queue entry: rd, wr, addr, four beats, four enable nibbles
  // ******************************
  logic [AW+161:0] cq[$];
  logic [39:0]     wq[int];
  int              rh[$];
  logic [AW:0]     ra[$];
  int              kc = 0;
  int              h;
  logic [AW+161:0] c;
  assign in_clk_n = ~in_clk;
  // clock pair held still until the bench lets it run
  initial begin
    in_clk = 1'b0;
    wait (go);
    forever #32 in_clk = ~in_clk;
  end
  initial begin
    {read_sel_n, write_sel_n} = 2'h3;
    addr_in = '0;
    {write_data_in, byte_lane_write_n} = '0;
    forever begin
      @(posedge in_clk or posedge in_clk_n);
      if (in_clk) kc++;
      h = in_clk ? 2 * kc - 1 : 2 * kc;
      // change mid-phase so every pin is settled around both rises
      #12;
      @(negedge clk);
      if (wq.exists(h)) {write_data_in, byte_lane_write_n} = wq[h];
      else {write_data_in, byte_lane_write_n} = ~{write_data_in, byte_lane_write_n};
      if (h % 2 == 0) begin
        c = (cq.size() > 0) ? cq.pop_front() : '0;
        {read_sel_n, write_sel_n} = ~c[AW+161:AW+160];
        addr_in = (c[AW+161] | c[AW+160]) ? c[AW+159:160] : ~addr_in;
        if (c[AW+161]) begin
          rh.push_back(h);
          ra.push_back({dll_off_n, c[AW+159:160]});
        end
        if (c[AW+160]) for (int k = 0; k < 4; k++) wq[h + 2 + k] = {c[16 + 36 * k +: 36], c[4 * k +: 4]};
      end
    end
  end
endmodule
`default_nettype wire

// file: dbsp_pkg.sv
// constants shared by the burst-of-four sram port
package dbsp_pkg;
  localparam int PORT_W       = 36;  // width of the data pins
  localparam int BYTE_W       = 9;   // one byte lane incl. parity bit
  localparam int PORT_LANES   = 4;   // byte-lane enables on the pins
  localparam int BURST        = 4;   // beats per burst
  localparam int LAT_ON       = 5;   // half cycles to first read beat, dll running (2.5 cycles)
  localparam int LAT_OFF      = 2;   // half cycles to first read beat, dll off (1.0 cycle)
  localparam int WR_LAT       = 2;   // half cycles to first write beat (1 cycle)
  localparam int PIPE_LEN     = 9;   // token positions 0..LAT_ON+BURST-1
  localparam int LOCK_K_CYCLES = 2048; // input-clock cycles to lock
  localparam int LOCK_CNT_W   = 16;
  localparam int CLK_PERIOD_NS = 8;  // system clock 125 MHz

  typedef enum logic [1:0] {
    DBSP_DLL_OFF  = 2'b00,
    DBSP_DLL_ACQ  = 2'b01,
    DBSP_DLL_LOCK = 2'b11
  } dbsp_dll_e;
endpackage

// file: dbsp_port.sv
// ddr burst-of-four sram port: command capture, burst pipes, array, echo clocks, dll model
//
// Contract
// R1: address and selects taken on true clock rise
// R2: write data taken on both clock rises
// R3: controller drives complement clock 180 degrees out
// R4: echo clocks toggle always, even when idle
// R5: echo edges aligned with read data changes
// R6: dll off bypasses dll, discards lock
// R7: dll on locks after lock time
// R8: dll off gives one cycle read latency
// R9: controller keeps clock under 167 MHz dll off
// R10: read-valid flag aligned with echo clocks
// R11: address ignored without read or write
// R12: write data width per configuration
// R13: read data width per configuration
// R14: read bus driven only for read commands
// R15: write select low starts write burst
// R16: read select low starts read burst
// R17: only enabled byte lanes are written
// R18: byte enable sampled with its data beat
// R19: dll on, first beat at 2.5 cycles
// R20: controller gives first write beat one cycle later
// R21: controller spaces reads two cycles apart
// R22: valid rises half cycle early, falls before last
// R23: read bus high impedance when idle
// R24: read and write on same edge both taken
`timescale 1ns/1ps
`default_nettype none
module dbsp_port #(
  parameter int ADDR_W      = 20,
  parameter bit WIDE        = 1'b0,
  parameter int LOCK_CYCLES = dbsp_pkg::LOCK_K_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic                        in_clk,
  input  wire logic                        in_clk_n,
  input  wire logic                        read_sel_n,
  input  wire logic                        write_sel_n,
  input  wire logic                        dll_off_n,
  input  wire logic [ADDR_W-1:0]           addr_in,
  input  wire logic [dbsp_pkg::PORT_W-1:0] write_data_in,
  input  wire logic [dbsp_pkg::PORT_LANES-1:0] byte_lane_write_n,
  output logic      [dbsp_pkg::PORT_W-1:0] read_data_out,
  output logic      [dbsp_pkg::PORT_W-1:0] read_data_oe,
  output logic                             echo_timing_out,
  output logic                             echo_timing_out_inv,
  output logic                             read_valid_flag,
  output logic                             dll_locked
);
  localparam int DW     = WIDE ? 36 : 18;
  localparam int LANES  = DW / dbsp_pkg::BYTE_W;
  localparam int MEM_AW = ADDR_W + 2;
  localparam int PL     = dbsp_pkg::PIPE_LEN;
  localparam int SYNC_W = ADDR_W + dbsp_pkg::PORT_W + dbsp_pkg::PORT_LANES + 2;
  localparam logic [dbsp_pkg::PORT_W-1:0] OE_MASK = dbsp_pkg::PORT_W'((37'h1 << DW) - 37'h1);

  // ********************************
  // pin synchronisers and clock edges
  // ********************************
  logic [2:0]        clk_sync;
  logic [SYNC_W-1:0] bus_sync;
  logic              in_clk_s;
  logic              in_clk_n_s;
  logic              dll_off_n_s;
  logic              in_clk_d;
  logic              in_clk_n_d;
  logic              rd_n_s;
  logic              wr_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [dbsp_pkg::PORT_W-1:0]   wdata_s;
  logic [dbsp_pkg::PORT_LANES-1:0] bw_n_s;
  logic              k_rise;
  logic              kn_rise;
  logic              half_edge;

  // clocks and commands share one delay so a detected edge sees its own setup window
  dbsp_sync #(.W(3)) u_sync_clk (
    .clk  (clk),
    .rstn (rstn),
    .d    ({in_clk, in_clk_n, dll_off_n}),
    .q    (clk_sync)
  );

  dbsp_sync #(.W(SYNC_W)) u_sync_bus (
    .clk  (clk),
    .rstn (rstn),
    .d    ({read_sel_n, write_sel_n, addr_in, write_data_in, byte_lane_write_n}),
    .q    (bus_sync)
  );

  assign in_clk_s    = clk_sync[2];
  assign in_clk_n_s  = clk_sync[1];
  assign dll_off_n_s = clk_sync[0];
  assign {rd_n_s, wr_n_s, addr_s, wdata_s, bw_n_s} = bus_sync;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      in_clk_d   <= 1'b0;
      in_clk_n_d <= 1'b0;
    end else begin
      in_clk_d   <= in_clk_s;
      in_clk_n_d <= in_clk_n_s;
    end
  end

  assign k_rise    = in_clk_s & ~in_clk_d;
  assign kn_rise   = in_clk_n_s & ~in_clk_n_d;
  assign half_edge = k_rise | kn_rise;

  // ********************************
  // command capture and burst pipes
  // ********************************
  logic              rd_go;
  logic              wr_go;
  logic [PL-1:0]     rd_tok;
  logic [PL-1:0]     wr_tok;
  logic [PL-1:0]     next_rd_tok;
  logic [PL-1:0]     next_wr_tok;
  logic [ADDR_W-1:0] rd_addr [PL];
  logic [ADDR_W-1:0] wr_addr [PL];
  int                lat;

  assign rd_go = k_rise & ~rd_n_s; // R1 R16 R24
  assign wr_go = k_rise & ~wr_n_s; // R1 R15 R24
  assign next_rd_tok = {rd_tok[PL-2:0], rd_go};
  assign next_wr_tok = {wr_tok[PL-2:0], wr_go};
  assign lat = dll_off_n_s ? dbsp_pkg::LAT_ON : dbsp_pkg::LAT_OFF; // R8 R19

  // tokens move one place per clock half, so one pipe serves both latencies
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_tok <= '0;
      wr_tok <= '0;
    end else if (half_edge) begin
      rd_tok <= next_rd_tok;
      wr_tok <= next_wr_tok;
    end
  end

  // address held only when a command is taken
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < PL; i++) begin
        rd_addr[i] <= '0;
        wr_addr[i] <= '0;
      end
    end else if (half_edge) begin
      if (rd_go) begin
        rd_addr[0] <= addr_s; // R11 R16
      end
      if (wr_go) begin
        wr_addr[0] <= addr_s; // R11 R15
      end
      for (int i = 1; i < PL; i++) begin
        rd_addr[i] <= rd_addr[i-1];
        wr_addr[i] <= wr_addr[i-1];
      end
    end
  end

  // ********************************
  // beat lookup
  // ********************************
  logic              rd_hit;
  logic              wr_hit;
  logic [MEM_AW-1:0] rd_idx;
  logic [MEM_AW-1:0] wr_idx;
  logic              next_valid;

  always_comb begin
    rd_hit = 1'b0;
    wr_hit = 1'b0;
    rd_idx = '0;
    wr_idx = '0;
    for (int k = 0; k < dbsp_pkg::BURST; k++) begin
      if (half_edge && next_rd_tok[lat+k]) begin
        rd_hit = 1'b1;
        rd_idx = {rd_addr[lat+k-1], 2'(k)};
      end
      if (half_edge && next_wr_tok[dbsp_pkg::WR_LAT+k]) begin
        wr_hit = 1'b1;
        wr_idx = {wr_addr[dbsp_pkg::WR_LAT+k-1], 2'(k)};
      end
    end
  end

  // a following burst bridges the drop so back-to-back reads keep the flag high
  assign next_valid = next_rd_tok[lat-1] | next_rd_tok[lat] | next_rd_tok[lat+1]
                    | (next_rd_tok[lat+2] & next_rd_tok[lat-2]); // R22

  // ********************************
  // array
  // ********************************
  logic [DW-1:0]               mem [2**MEM_AW];
  logic [dbsp_pkg::PORT_W-1:0] rd_word;

  // only low data bits of the narrow configuration reach the array
  always_ff @(posedge clk) begin
    if (wr_hit) begin
      for (int b = 0; b < LANES; b++) begin
        if (!bw_n_s[b]) begin
          mem[wr_idx][b*dbsp_pkg::BYTE_W +: dbsp_pkg::BYTE_W] <=
            wdata_s[b*dbsp_pkg::BYTE_W +: dbsp_pkg::BYTE_W]; // R2 R12 R17 R18
        end
      end
    end
  end

  always_comb begin
    rd_word = '0;
    rd_word[DW-1:0] = mem[rd_idx]; // R13
  end

  // ********************************
  // read outputs and echo clocks
  // ********************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      read_data_out   <= '0;
      read_data_oe    <= '0;
      read_valid_flag <= 1'b0;
    end else if (half_edge) begin
      read_valid_flag <= next_valid; // R10 R22
      if (rd_hit) begin
        read_data_out <= rd_word; // R14 R19 R8
        read_data_oe  <= OE_MASK; // R13
      end else begin
        read_data_oe  <= '0; // R23
      end
    end
  end

  // registered in the same cycle as the data, so edges line up
  always_ff @(posedge clk) begin
    if (!rstn) begin
      echo_timing_out     <= 1'b0;
      echo_timing_out_inv <= 1'b0;
    end else begin
      echo_timing_out     <= in_clk_s; // R4 R5
      echo_timing_out_inv <= in_clk_n_s; // R4 R5
    end
  end

  // ********************************
  // dll model
  // ********************************
  dbsp_pkg::dbsp_dll_e            dll_state;
  logic [dbsp_pkg::LOCK_CNT_W-1:0] lock_cnt;

  // the lock time is counted in input-clock cycles, not system cycles
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dll_state <= dbsp_pkg::DBSP_DLL_OFF;
      lock_cnt  <= '0;
    end else if (!dll_off_n_s) begin
      dll_state <= dbsp_pkg::DBSP_DLL_OFF; // R6
      lock_cnt  <= '0; // R6
    end else begin
      case (dll_state)
        dbsp_pkg::DBSP_DLL_OFF: begin
          dll_state <= dbsp_pkg::DBSP_DLL_ACQ;
        end
        dbsp_pkg::DBSP_DLL_ACQ: begin
          if (k_rise) begin
            if (lock_cnt == dbsp_pkg::LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
              dll_state <= dbsp_pkg::DBSP_DLL_LOCK; // R7
            end else begin
              lock_cnt <= lock_cnt + 1'b1;
            end
          end
        end
        dbsp_pkg::DBSP_DLL_LOCK: begin
          dll_state <= dbsp_pkg::DBSP_DLL_LOCK;
        end
        default: begin
          dll_state <= dbsp_pkg::DBSP_DLL_OFF;
        end
      endcase
    end
  end
  assign dll_locked = (dll_state == dbsp_pkg::DBSP_DLL_LOCK);

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_beat_on;
    half_edge && next_rd_tok[dbsp_pkg::LAT_ON] && dll_off_n_s;
  endsequence
  sequence s_beat_off;
    half_edge && next_rd_tok[dbsp_pkg::LAT_OFF] && !dll_off_n_s;
  endsequence
  sequence s_both_cmds;
    k_rise && !rd_n_s && !wr_n_s;
  endsequence

  a_read_lat_on: // R19
    assert property (s_beat_on |=> read_data_oe[0] && echo_timing_out_inv)
    else $error("first read beat not on complement clock at 2.5 cycles");
  a_read_lat_off: // R8
    assert property (s_beat_off |=> read_data_oe[0] && echo_timing_out)
    else $error("first read beat not at one cycle with dll off");
  a_idle_hiz: // R23
    assert property ((rd_tok == '0) |-> (read_data_oe == '0))
    else $error("read bus driven with no burst in flight");
  a_oe_needs_read: // R14
    assert property ((|read_data_oe) |-> (|rd_tok))
    else $error("read bus driven without a read command");
  a_addr_ignored: // R11
    assert property (k_rise && rd_n_s && wr_n_s |=> !rd_tok[0] && !wr_tok[0])
    else $error("command started while deselected");
  a_same_edge: // R24
    assert property (s_both_cmds |=> rd_tok[0] && wr_tok[0])
    else $error("read and write on one edge not both taken");
  a_echo_free: // R4
    assert property (k_rise |=> echo_timing_out ##1 echo_timing_out)
    else $error("echo clock not following input clock");
  a_valid_leads: // R22
    assert property ($rose(read_valid_flag) |-> read_data_oe == '0 ##[1:8] read_data_oe[0])
    else $error("valid flag not half a cycle ahead of data");
  a_valid_falls: // R22
    assert property ($fell(read_valid_flag) |-> read_data_oe[0])
    else $error("valid flag fell outside the burst");
  a_dll_reset: // R6
    assert property (!dll_off_n_s |=> !dll_locked && lock_cnt == '0)
    else $error("dll lock kept while disabled");
  a_lock_time: // R7
    assert property ($rose(dll_locked) |-> lock_cnt == dbsp_pkg::LOCK_CNT_W'(LOCK_CYCLES - 1))
    else $error("dll locked before lock time");
  a_lane_mask: // R17
    assert property (wr_hit && (&bw_n_s[LANES-1:0]) |=> mem[$past(wr_idx)] == $past(mem[wr_idx]))
    else $error("masked write changed the array");
endmodule
`default_nettype wire

// file: dbsp_port_tb.sv
// self-checking bench for the burst-of-four sram port
`timescale 1ns/1ps
`default_nettype none
module dbsp_port_tb;
  localparam int AW = 4;
  logic        clk, rstn, go, dll_off_n, in_clk, in_clk_n, read_sel_n, write_sel_n;
  logic [AW-1:0] addr_in;
  logic [35:0] write_data_in, read_data_out, read_data_oe, eo;
  logic [3:0]  byte_lane_write_n;
  logic        echo_timing_out, echo_timing_out_inv, read_valid_flag, dll_locked;
  logic [35:0] read_data_out_w, read_data_oe_w;
  logic        echo_w, echo_inv_w, valid_w, locked_w;
  logic [35:0] mem [64];
  logic [35:0] ed;
  logic [31:0] seed = 32'h2A;
  logic [31:0] v;
  logic        pe = 1'b0, pi = 1'b0, ev, fl;
  int          n_fail = 0, checks = 0, t = 0, ph = 0, hn, f;

  dbsp_port #(.ADDR_W(AW), .WIDE(1'b0), .LOCK_CYCLES(4)) i_dbsp_port (
    .clk(clk), .rstn(rstn), .in_clk(in_clk), .in_clk_n(in_clk_n), .read_sel_n(read_sel_n),
    .write_sel_n(write_sel_n), .dll_off_n(dll_off_n), .addr_in(addr_in), .write_data_in(write_data_in),
    .byte_lane_write_n(byte_lane_write_n), .read_data_out(read_data_out), .read_data_oe(read_data_oe),
    .echo_timing_out(echo_timing_out), .echo_timing_out_inv(echo_timing_out_inv),
    .read_valid_flag(read_valid_flag), .dll_locked(dll_locked));
  // second port in the wide configuration shares the controller pins
  dbsp_port #(.ADDR_W(AW), .WIDE(1'b1), .LOCK_CYCLES(4)) i_dbsp_port_wide (
    .clk(clk), .rstn(rstn), .in_clk(in_clk), .in_clk_n(in_clk_n), .read_sel_n(read_sel_n),
    .write_sel_n(write_sel_n), .dll_off_n(dll_off_n), .addr_in(addr_in), .write_data_in(write_data_in),
    .byte_lane_write_n(byte_lane_write_n), .read_data_out(read_data_out_w), .read_data_oe(read_data_oe_w),
    .echo_timing_out(echo_w), .echo_timing_out_inv(echo_inv_w),
    .read_valid_flag(valid_w), .dll_locked(locked_w));
  dbsp_ctrl #(.AW(AW)) i_dbsp_ctrl (
    .clk(clk), .go(go), .dll_off_n(dll_off_n), .in_clk(in_clk), .in_clk_n(in_clk_n),
    .read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .addr_in(addr_in),
    .write_data_in(write_data_in), .byte_lane_write_n(byte_lane_write_n));

  // ******************************
  // helpers
  // ******************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int first(int j);
    return i_dbsp_ctrl.rh[j] + (i_dbsp_ctrl.ra[j][AW] ? 5 : 2);
  endfunction
  task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // model is updated at push; op waits for an empty queue so pushes stay paced
  task automatic op(input logic rd, input logic wr, input logic [AW-1:0] a, input logic [15:0] be);
    logic [159:0] r;
    r = {rnd(), rnd(), rnd(), rnd(), rnd()};
    wait (i_dbsp_ctrl.cq.size() == 0);
    for (int k = 0; k < 4; k++)
      for (int l = 0; l < 4; l++)
        if (wr && !be[4 * k + l]) mem[{a, 2'(k)}][9 * l +: 9] = r[36 * k + 9 * l +: 9];
    i_dbsp_ctrl.cq.push_back({rd, wr, a, r[143:0], be});
    i_dbsp_ctrl.cq.push_back('0);
  endtask
  task automatic drain(input string nm);
    wait (i_dbsp_ctrl.cq.size() == 0);
    repeat (8) @(posedge in_clk);
    @(negedge clk);
    $display("test %s done, checks %0d", nm, checks);
  endtask
  task automatic results();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ******************************
  // read side monitor, judged at every echo edge
  // ******************************
  always @(negedge clk) begin
    ev = (echo_timing_out & ~pe) | (echo_timing_out_inv & ~pi);
    if (echo_timing_out & ~pe) begin
      t++;
      ph = 0;
    end else if (echo_timing_out_inv & ~pi) ph = 1;
    pe = echo_timing_out;
    pi = echo_timing_out_inv;
    hn = 2 * t - 2 + ph;
    if (ev && t > 0) begin
      fl = 1'b0;
      eo = '0;
      ed = '0;
      foreach (i_dbsp_ctrl.rh[j]) begin
        f = first(j);
        if (hn >= f - 1 && hn <= f + 1) fl = 1'b1;
        if (hn == f + 2 && j + 1 < i_dbsp_ctrl.rh.size() && first(j + 1) == f + 4) fl = 1'b1;
        if (hn >= f && hn <= f + 3) begin
          eo = 36'h00003FFFF;
          ed = mem[{i_dbsp_ctrl.ra[j][AW-1:0], 2'(hn - f)}];
        end
      end
      chk("read_valid_flag", {35'h0, fl}, {35'h0, read_valid_flag});
      chk("wide read_valid_flag", {35'h0, fl}, {35'h0, valid_w});
      chk("wide echo pair", {34'h0, ph == 0, ph == 1}, {34'h0, echo_w, echo_inv_w});
      chk("read_data_oe", eo, read_data_oe);
      chk("wide read_data_oe", {36{eo[0]}}, read_data_oe_w);
      if (eo != 0) chk("read_data_out", {18'h0, ed[17:0]}, read_data_out);
      if (eo != 0) chk("wide read_data_out", ed, read_data_out_w);
    end
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #200000;
    n_fail++;
    results();
  end
  initial begin
    rstn = 1'b0;
    go = 1'b0;
    dll_off_n = 1'b1;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    go = 1'b1;
    for (int a = 0; a < 16; a++) op(1'b0, 1'b1, AW'(a), 16'h0000);
    drain("fill");
    repeat (24) op(1'b0, 1'b1, AW'(rnd()), 16'(rnd()));
    drain("byte lanes");
    for (int a = 0; a < 16; a++) op(1'b1, 1'b0, AW'(a), 16'h0000);
    drain("back to back reads");
    op(1'b1, 1'b1, 4'h3, 16'h00F0);
    for (int i = 1; i < 17; i++) begin
      v = rnd();
      op(v[0], v[1], AW'(5 * i), v[31:16]);
    end
    drain("mixed");
    chk("dll_locked", 36'h1, {35'h0, dll_locked});
    dll_off_n = 1'b0;
    repeat (3) @(posedge in_clk);
    @(negedge clk);
    chk("dll_locked", 36'h0, {35'h0, dll_locked});
    chk("wide dll_locked", 36'h0, {35'h0, locked_w});
    for (int a = 15; a >= 0; a--) op(1'b1, 1'b0, AW'(a), 16'hFFFF);
    drain("dll off reads");
    dll_off_n = 1'b1;
    repeat (2) @(posedge in_clk);
    @(negedge clk);
    chk("dll_locked", 36'h0, {35'h0, dll_locked});
    repeat (6) @(posedge in_clk);
    @(negedge clk);
    chk("dll_locked", 36'h1, {35'h0, dll_locked});
    chk("wide dll_locked", 36'h1, {35'h0, locked_w});
    chk("echo count", 36'h1, {35'h0, t + 2 >= i_dbsp_ctrl.kc});
    $display("test dll relock done, checks %0d", checks);
    results();
  end
endmodule
`default_nettype wire

// file: dbsp_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module dbsp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // meta feeds only the second flop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire
